// *** sar_adc_conversion_sequencer.sv ***
// Function
// RQ1: Trigger source zero: only the go bit starts conversions; trigger ignored.
// RQ2: Trigger source one: capture unit period trigger pulse starts conversions.
// RQ3: Writing one to go starts conversion on the selected channel.
// RQ4: Start begins sampling, sets busy and clears the go bit.
// RQ5: Repeat select zero is single mode (reset value); one is continuous.
// RQ6: Single mode completion raises the done flag and stores the result byte.
// RQ7: Continuous mode repeats conversions; go cleared only at the first start.
// RQ8: Continuous mode keeps busy until the last one; done flag every conversion.
// RQ9: Clearing repeat select ends continuous mode after the running conversion.
// RQ10: Channel changes in continuous mode apply to following conversions.
// RQ11: New starts are accepted only after the running conversion completes.
// RQ12: Software should let conversions finish before changing trigger source.
// RQ13: Power-down or the off request disables the converter.
// RQ14: An off request during conversion waits for that conversion to finish.
// RQ15: Software waits for conversions to finish before entering power-down.
// RQ16: Divider and sample length writes take effect from the next conversion.
// RQ17: Converter clock is system clock divided by 32 minus four per code.
// RQ18: Sample phase is two converter clocks plus two per code step.
// RQ19: Phases: sync two clocks, sample, eight approximation clocks, write.
// RQ20: Approximation end clears busy, sets done; result written next phase.
// RQ21: Only the low repeat select bit chooses the mode.
// RQ22: Off status reads one while disabled and converter clock is gated.
// RQ23: Go writes under hardware source never start; busy-time triggers dropped.
// RQ24: Channel is captured at sample start and held until completion.
module sar_adc_conversion_sequencer #(
   parameter int CHAN_W = 3
) (
   // Clock and reset.
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // AXI4-Lite write address and data.
   input  wire logic [7:0]                s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [7:0]                s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // Trigger and chip power state.
   input  wire logic                      capture_unit_period_trigger,
   input  wire logic                      chip_power_down,
   // Analog front end.
   input  wire logic                      comparator_high,
   output sar_seq_pkg::front_end_t        front_end,
   // Status lines.
   output logic                           conversion_done_irq_flag,
   output logic                           converter_off_state
);
   import sar_seq_pkg::*;

   // Elaboration checks: the counters below are sized for these ranges.
   if (CHAN_W < 1 || CHAN_W > 3) begin : g_chan_w_chk
      $error("CHAN_W must be between 1 and 3");
   end
   if (DIV_MAX >= 2 ** CNT_W || DIV_MAX < 7 * DIV_STEP + 2) begin : g_div_chk
      $error("Converter clock divider does not fit its counter");
   end
   if (SAMPLE_BASE + 7 * SAMPLE_STEP > 31) begin : g_sample_chk
      $error("Sample length does not fit its counter");
   end


   main_ctrl_t    main_reg;
   timing_ctrl_t  timing_reg;
   logic [7:0]    result_byte_reg;
   logic          off_request_reg;
   seq_state_t    state_reg;
   logic [CNT_W-1:0] div_cnt_reg;
   logic [CNT_W-1:0] div_len_reg;
   logic [4:0]    period_cnt_reg;
   logic [4:0]    sample_len_reg;
   logic [2:0]    bit_idx_reg;
   logic [7:0]    sar_reg;
   logic          aw_held_reg;
   logic          w_held_reg;
   logic [7:0]    aw_addr_reg;
   logic [31:0]   w_data_reg;
   logic [3:0]    w_strb_reg;

   logic          start;
   logic          tick;
   logic          last_period;
   logic          continue_run;
   logic          wr_fire;
   logic          wr_lane0;
   logic          go_write;
   logic          done_clear;
   logic          sync_last;
   logic          conv_last;
   logic          converter_on;

   function automatic logic addr_mapped(input logic [7:0] a);
      return a == MAIN_CTRL_ADDR || a == TIMING_CTRL_ADDR ||
             a == RESULT_ADDR || a == OFF_CTRL_ADDR ||
             a == OFF_STATUS_ADDR || a == IRQ_FLAGS_ADDR;
   endfunction

   function automatic logic [CNT_W-1:0] div_of(input logic [2:0] code);
      return CNT_W'(DIV_MAX - DIV_STEP * int'(code)); // RQ17
   endfunction

   function automatic logic [4:0] sample_of(input logic [2:0] code);
      return 5'(SAMPLE_BASE + SAMPLE_STEP * int'(code)); // RQ18
   endfunction

   // Starts are taken only from idle, so triggers during a run are dropped.
   always_comb begin
      start = 1'b0;
      // The off request blocks here too, else a start in the cycle that
      // raises the off status would run a conversion while reported off.
      if (state_reg == ST_IDLE && converter_on) begin // RQ11 RQ13
         if (main_reg.trigger_source_select) begin
            start = capture_unit_period_trigger; // RQ2 RQ23
         end else begin
            start = main_reg.go; // RQ1 RQ3
         end
      end
   end

   assign tick        = div_cnt_reg == div_len_reg - CNT_W'(1);
   assign last_period = period_cnt_reg == sample_len_reg - 5'd1;
   // An off request or power-down ends a continuous run at its next end.
   assign converter_on = !off_request_reg && !chip_power_down; // RQ13
   assign continue_run = main_reg.repeat_select[0] && // RQ21 RQ9
                         converter_on; // RQ14
   assign sync_last    = state_reg == ST_SYNC &&
                         period_cnt_reg == 5'(SYNC_CYCLES - 1);
   assign conv_last    = state_reg == ST_CONV && tick && bit_idx_reg == 3'h0;
   assign wr_fire  = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_lane0 = wr_fire && w_strb_reg[0];
   assign go_write = wr_lane0 && aw_addr_reg == MAIN_CTRL_ADDR;
   assign done_clear = wr_lane0 && aw_addr_reg == IRQ_FLAGS_ADDR &&
                       w_data_reg[DONE_BIT];

   // Conversion phase sequencer.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg      <= ST_IDLE;
         div_cnt_reg    <= '0;
         div_len_reg    <= div_of(3'h0);
         period_cnt_reg <= '0;
         sample_len_reg <= sample_of(3'h0);
         bit_idx_reg    <= 3'h7;
         sar_reg        <= 8'h00;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  state_reg      <= ST_SYNC;
                  period_cnt_reg <= '0;
               end
            end
            ST_SYNC: begin // RQ19
               period_cnt_reg <= period_cnt_reg + 5'd1;
               if (sync_last) begin
                  state_reg      <= ST_SAMPLE;
                  period_cnt_reg <= '0;
                  div_cnt_reg    <= '0;
                  // Timing fields are frozen per conversion.
                  div_len_reg    <= div_of(timing_reg.conv_clock_divider_select); // RQ16
                  sample_len_reg <= sample_of(timing_reg.sample_length_select); // RQ16
               end
            end
            ST_SAMPLE: begin
               div_cnt_reg <= tick ? '0 : div_cnt_reg + CNT_W'(1);
               if (tick) begin
                  period_cnt_reg <= period_cnt_reg + 5'd1;
                  if (last_period) begin
                     state_reg   <= ST_CONV;
                     bit_idx_reg <= 3'h7;
                     sar_reg     <= 8'h80;
                  end
               end
            end
            ST_CONV: begin // RQ19
               div_cnt_reg <= tick ? '0 : div_cnt_reg + CNT_W'(1);
               if (tick) begin
                  // The trial code reaches the front end a cycle late, which
                  // the divider of at least two hides from the comparator.
                  sar_reg[bit_idx_reg] <= comparator_high;
                  if (bit_idx_reg != 3'h0) begin
                     sar_reg[bit_idx_reg - 3'h1] <= 1'b1;
                     bit_idx_reg <= bit_idx_reg - 3'h1;
                  end else begin
                     state_reg <= ST_WRITE;
                  end
               end
            end
            ST_WRITE: begin
               period_cnt_reg <= '0;
               state_reg <= continue_run ? ST_SYNC : ST_IDLE; // RQ7 RQ9
            end
         endcase
      end
   end

   // Analog front end drive; the converter clock enable stops while off.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         front_end <= '0;
      end else begin
         // Raised with the phase itself so the switch spans every sample
         // period; a late rise would cut the first period short.
         front_end.sample_en   <= sync_last || // RQ18
                                  (state_reg == ST_SAMPLE &&
                                   !(tick && last_period));
         front_end.conv_clk_en <= (state_reg == ST_SAMPLE || state_reg == ST_CONV)
                                  && tick; // RQ22
         front_end.trial_code  <= sar_reg;
         if (sync_last) begin
            front_end.channel <= 3'(main_reg.input_channel_select[CHAN_W-1:0]); // RQ24 RQ10
         end
      end
   end

   // Main control byte: go, busy and software fields.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         main_reg <= MAIN_CTRL_RST; // RQ5
      end else begin
         if (go_write) begin
            main_reg.input_channel_select  <= w_data_reg[CHAN_LSB +: 3];
            main_reg.trigger_source_select <= w_data_reg[SRC_BIT];
            main_reg.repeat_select         <= w_data_reg[MODE_BIT +: 2];
         end
         if (start) begin
            main_reg.go <= 1'b0; // RQ4 RQ7
         end
         // A go write under the hardware source is dropped.
         if (go_write && w_data_reg[GO_BIT] &&
             !w_data_reg[SRC_BIT]) begin
            main_reg.go <= 1'b1; // RQ3 RQ23
         end
         // Busy rises with the sample phase; a continuous run keeps it up
         // through the write and sync gaps between conversions.
         if (state_reg == ST_SAMPLE && div_cnt_reg == '0 &&
             period_cnt_reg == '0) begin
            main_reg.busy <= 1'b1; // RQ4
         end
         if (conv_last && !continue_run) begin
            main_reg.busy <= 1'b0; // RQ20 RQ8
         end
      end
   end

   // Result byte and done flag; a set in the clearing cycle wins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_byte_reg          <= RESULT_RST;
         conversion_done_irq_flag <= 1'b0;
      end else begin
         if (state_reg == ST_WRITE) begin
            result_byte_reg <= sar_reg; // RQ6 RQ20
         end
         if (done_clear) begin
            conversion_done_irq_flag <= 1'b0;
         end
         if (conv_last) begin
            conversion_done_irq_flag <= 1'b1; // RQ6 RQ8 RQ20
         end
      end
   end

   // Timing fields may be written at any time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timing_reg <= TIMING_CTRL_RST;
      end else if (wr_lane0 && aw_addr_reg == TIMING_CTRL_ADDR) begin
         timing_reg <= w_data_reg[5:0]; // RQ16
      end
   end

   // Off request and status; status rises only between conversions.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         off_request_reg     <= 1'b0;
         converter_off_state <= 1'b0;
      end else begin
         if (wr_lane0 && aw_addr_reg == OFF_CTRL_ADDR) begin
            off_request_reg <= w_data_reg[OFF_BIT];
         end
         if (converter_on) begin
            converter_off_state <= 1'b0; // RQ22
         end else if (state_reg == ST_IDLE) begin
            converter_off_state <= 1'b1; // RQ13 RQ14
         end
      end
   end

   // AXI write channels: address and data are taken in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         aw_addr_reg   <= 8'h00;
         w_data_reg    <= 32'h0000_0000;
         w_strb_reg    <= 4'h0;
      end else begin
         s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_held_reg;
         s_axi_wready  <= !s_axi_wready && s_axi_wvalid && !w_held_reg;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         // A held pair waits for the pending response, so one write is open.
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
         end
      end
   end

   // Write response; unmapped addresses answer with a slave error.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel; reserved bits read as zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
               MAIN_CTRL_ADDR:   s_axi_rdata <= {24'h0, main_reg};
               TIMING_CTRL_ADDR: s_axi_rdata <= {26'h0, timing_reg};
               RESULT_ADDR:      s_axi_rdata <= {24'h0, result_byte_reg};
               OFF_CTRL_ADDR:    s_axi_rdata <= {31'h0, off_request_reg};
               OFF_STATUS_ADDR:  s_axi_rdata <= {31'h0, converter_off_state};
               IRQ_FLAGS_ADDR:   s_axi_rdata <= {31'h0, conversion_done_irq_flag};
               default:          s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// *** sar_seq_pkg.sv ***
package sar_seq_pkg;

   // Register byte addresses.
   localparam logic [7:0] MAIN_CTRL_ADDR   = 8'h00;
   localparam logic [7:0] TIMING_CTRL_ADDR = 8'h04;
   localparam logic [7:0] RESULT_ADDR      = 8'h08;
   localparam logic [7:0] OFF_CTRL_ADDR    = 8'h0C;
   localparam logic [7:0] OFF_STATUS_ADDR  = 8'h10;
   localparam logic [7:0] IRQ_FLAGS_ADDR   = 8'h14;

   // Field positions inside the main control byte, the timing byte and the off and flag registers.
   localparam int CHAN_LSB  = 0;
   localparam int SRC_BIT   = 3;
   localparam int MODE_BIT  = 4;
   localparam int BUSY_BIT  = 6;
   localparam int GO_BIT    = 7;
   localparam int CTC_LSB   = 0;
   localparam int STC_LSB   = 3;
   localparam int OFF_BIT   = 0;
   localparam int DONE_BIT  = 0;

   // Reset values.
   localparam logic [7:0] MAIN_CTRL_RST   = 8'h00;
   localparam logic [5:0] TIMING_CTRL_RST = 6'h00;
   localparam logic [7:0] RESULT_RST      = 8'h00;

   // Timing figures in cycles of the system clock or converter clock; CNT_W is the divider counter width.
   localparam int SYNC_CYCLES   = 2;
   localparam int DIV_MAX       = 32;
   localparam int DIV_STEP      = 4;
   localparam int SAMPLE_BASE   = 2;
   localparam int SAMPLE_STEP   = 2;
   localparam int CONV_PERIODS  = 8;
   localparam int CNT_W         = 6;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       go;
      logic       busy;
      logic [1:0] repeat_select;
      logic       trigger_source_select;
      logic [2:0] input_channel_select;
   } main_ctrl_t;

   typedef struct packed {
      logic [2:0] sample_length_select;
      logic [2:0] conv_clock_divider_select;
   } timing_ctrl_t;

   typedef struct packed {
      logic       sample_en;
      logic       conv_clk_en;
      logic [2:0] channel;
      logic [7:0] trial_code;
   } front_end_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SYNC,
      ST_SAMPLE,
      ST_CONV,
      ST_WRITE
   } seq_state_t;

endpackage

// *** sar_seq_asserts.sv ***
module sar_seq_asserts
   import sar_seq_pkg::*;
#(
   parameter int CHAN_W = 3
) (
   // Clock and reset.
   input wire logic                    aclk,
   input wire logic                    aresetn,
   // Bus answers.
   input wire logic                    s_axi_awready,
   input wire logic [1:0]              s_axi_bresp,
   input wire logic                    s_axi_bvalid,
   input wire logic                    s_axi_bready,
   input wire logic [31:0]             s_axi_rdata,
   input wire logic                    s_axi_rvalid,
   input wire logic                    s_axi_rready,
   // Converter side.
   input wire logic                    chip_power_down,
   input wire sar_seq_pkg::front_end_t front_end,
   input wire logic                    conversion_done_irq_flag,
   input wire logic                    converter_off_state
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // The longest conversion stays under 800 cycles, so 1023 cycles of
   // power-down leave room for a running conversion to finish first.
   logic [9:0] pd_cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn || !chip_power_down) begin
         pd_cnt <= 10'h000;
      end else if (pd_cnt != 10'h3FF) begin
         pd_cnt <= pd_cnt + 10'h001;
      end
   end

   AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready stood longer than one cycle");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before it was taken");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before it was taken");
   AST_CHAN_HELD: assert property (
      front_end.sample_en && $past(front_end.sample_en)
      |-> $stable(front_end.channel))
      else $error("channel moved during sampling");
   AST_OFF_NO_SAMPLE: assert property (
      converter_off_state |-> !front_end.sample_en)
      else $error("sampling while converter is off");
   AST_OFF_GATED: assert property (
      converter_off_state |-> !front_end.conv_clk_en)
      else $error("converter clock runs while off");
   AST_PD_OFF: assert property (
      pd_cnt == 10'h3FF |-> converter_off_state)
      else $error("power-down did not disable the converter");
   AST_TICK_GAP: assert property (
      front_end.conv_clk_en |=> !front_end.conv_clk_en [*3])
      else $error("converter clock faster than divide by four");
   AST_SAMPLE_MIN: assert property (
      $rose(front_end.sample_en) |=> front_end.sample_en [*7])
      else $error("sample phase shorter than two periods");
   AST_DONE_AFTER_CONV: assert property (
      $rose(conversion_done_irq_flag) |-> !front_end.sample_en)
      else $error("done flag raised during sampling");
endmodule

bind sar_adc_conversion_sequencer sar_seq_asserts #(.CHAN_W(CHAN_W))
   i_sar_seq_asserts (.aclk, .aresetn, .s_axi_awready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .chip_power_down, .front_end,
   .conversion_done_irq_flag, .converter_off_state);

// *** sar_front_model.sv ***
module sar_front_model (
   // Clock.
   input wire logic                    aclk,
   // Analog side.
   input wire logic [7:0]              level,
   input wire sar_seq_pkg::front_end_t front_end,
   output logic                        comparator_high
);
   import sar_seq_pkg::*;
   // The array holds the input like a capacitor, so a level change after
   // the sample phase only reaches the next conversion.
   logic [7:0] held;
   always_ff @(posedge aclk) begin
      if (front_end.sample_en) begin
         held <= level;
      end
   end
   assign comparator_high = (held >= front_end.trial_code);
endmodule

// *** tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sar_seq_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b1;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b1;
   logic        capture_unit_period_trigger = 1'b0;
   logic        chip_power_down = 1'b0;
   logic        comparator_high;
   front_end_t  front_end;
   logic        conversion_done_irq_flag;
   logic        converter_off_state;
   logic [7:0]  level = 8'h00;
   logic [9:0]  samp_cur = 10'h000;
   logic [9:0]  samp_len = 10'h000;
   logic [1:0]  resp;
   logic [31:0] rdat;
   int          fails = 0;
   int          comparisons = 0;

   always #20 aclk = ~aclk;

   sar_adc_conversion_sequencer #(.CHAN_W(3)) i_sar_adc_conversion_sequencer (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .capture_unit_period_trigger, .chip_power_down,
      .comparator_high, .front_end, .conversion_done_irq_flag,
      .converter_off_state);
   sar_front_model i_sar_front_model (.aclk, .level, .front_end,
      .comparator_high);

   always @(posedge aclk) begin
      if (front_end.sample_en) begin
         samp_cur <= samp_cur + 10'h001;
      end else if (samp_cur != 10'h000) begin
         samp_len <= samp_cur;
         samp_cur <= 10'h000;
      end
   end

   task automatic results;
      if (fails == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string n, input logic [31:0] e,
                        input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      resp = s_axi_bresp;
   endtask

   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
      rd(a);
      check(n, e, rdat);
   endtask

   task automatic pulse;
      capture_unit_period_trigger <= 1'b1;
      @(posedge aclk);
      capture_unit_period_trigger <= 1'b0;
   endtask

   task automatic wait_done;
      for (int i = 0; i < 2000 && conversion_done_irq_flag !== 1'b1; i++)
         @(posedge aclk);
      check("done flag", 32'h1, {31'h0, conversion_done_irq_flag});
   endtask

   task automatic wait_sample;
      for (int i = 0; i < 100 && front_end.sample_en !== 1'b1; i++)
         @(posedge aclk);
   endtask

   task automatic conv(input logic [7:0] c, input logic [7:0] v,
                       input logic [9:0] n);
      level <= v;
      wr(MAIN_CTRL_ADDR, {24'h0, c});
      wait_done();
      check("sample length", {22'h0, n}, {22'h0, samp_len});
      rc(RESULT_ADDR, {24'h0, v}, "result");
      wr(IRQ_FLAGS_ADDR, 32'h1);
   endtask

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int a = 0; a < 'h18; a += 4) begin
         rc(8'(a), 32'h0, "reset value");
      end
      rd(8'h18);
      check("read resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      wr(8'h18, 32'hFF);
      check("write resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      pulse();
      repeat (20) @(posedge aclk);
      rc(MAIN_CTRL_ADDR, 32'h0, "trigger ignored");
      wr(TIMING_CTRL_ADDR, 32'h07);
      level <= 8'hA5;
      wr(MAIN_CTRL_ADDR, 32'h82);
      wait_sample();
      check("channel", 32'h2, {29'h0, front_end.channel});
      rc(MAIN_CTRL_ADDR, 32'h42, "busy set");
      wr(TIMING_CTRL_ADDR, 32'h0F);
      wait_done();
      check("sample length", 32'd8, {22'h0, samp_len});
      rc(RESULT_ADDR, 32'hA5, "result");
      rc(MAIN_CTRL_ADDR, 32'h02, "busy clear");
      wr(IRQ_FLAGS_ADDR, 32'h1);
      check("done clear", 32'h0, {31'h0, conversion_done_irq_flag});
      conv(8'h80, 8'h5A, 10'd16);
      for (int c = 0; c < 8; c += 3) begin
         wr(TIMING_CTRL_ADDR, 32'(c * 9));
         conv(8'h80, 8'(c * 37), 10'((2 + 2 * c) * (32 - 4 * c)));
      end
      wr(MAIN_CTRL_ADDR, 32'h88);
      rc(MAIN_CTRL_ADDR, 32'h08, "go dropped");
      level <= 8'hC3;
      pulse();
      wait_sample();
      pulse();
      wait_done();
      rc(RESULT_ADDR, 32'hC3, "triggered result");
      wr(IRQ_FLAGS_ADDR, 32'h1);
      repeat (20) @(posedge aclk);
      rc(MAIN_CTRL_ADDR, 32'h08, "busy trigger dropped");
      wr(MAIN_CTRL_ADDR, 32'h00);
      level <= 8'h11;
      wr(MAIN_CTRL_ADDR, 32'h91);
      wait_done();
      rc(MAIN_CTRL_ADDR, 32'h51, "repeat busy");
      wr(IRQ_FLAGS_ADDR, 32'h1);
      level <= 8'h22;
      wr(MAIN_CTRL_ADDR, 32'h13);
      wait_done();
      wr(IRQ_FLAGS_ADDR, 32'h1);
      wait_sample();
      check("new channel", 32'h3, {29'h0, front_end.channel});
      wr(MAIN_CTRL_ADDR, 32'h03);
      wait_done();
      rc(RESULT_ADDR, 32'h22, "repeat result");
      repeat (20) @(posedge aclk);
      rc(MAIN_CTRL_ADDR, 32'h03, "stopped");
      wr(IRQ_FLAGS_ADDR, 32'h1);
      level <= 8'h44;
      wr(MAIN_CTRL_ADDR, 32'h82);
      wait_sample();
      wr(OFF_CTRL_ADDR, 32'h1);
      rc(OFF_STATUS_ADDR, 32'h0, "off waits");
      wait_done();
      repeat (4) @(posedge aclk);
      rc(OFF_STATUS_ADDR, 32'h1, "off status");
      rc(RESULT_ADDR, 32'h44, "last result");
      wr(OFF_CTRL_ADDR, 32'h0);
      rc(OFF_STATUS_ADDR, 32'h0, "on again");
      wr(IRQ_FLAGS_ADDR, 32'h1);
      // Idle here, so power-down is safe to enter at once.
      chip_power_down <= 1'b1;
      repeat (1100) @(posedge aclk);
      rc(OFF_STATUS_ADDR, 32'h1, "power down");
      chip_power_down <= 1'b0;
      rc(OFF_STATUS_ADDR, 32'h0, "power up");
      results();
   end

   initial begin
      #2000000;
      fails++;
      results();
   end
endmodule
